// ---- asp_serial_port.v ----
// serial host port of the converter: command byte decode, register read
// shifting on the shared data-out/ready pin, write word assembly into a
// buffer toward the register file, and the ready indication.
// assumes the serial clock, select and data-in pins come from the host and are
// sampled by clk; register contents other than the data register and all
// conversion timing live outside and reach this block by plain ports.
`timescale 1ns/10ps
`include "asp_consts.vh"

module asp_serial_port #(
    parameter DATA_W = `ASP_DATA_W,
    parameter FIFO_DEPTH = `ASP_FIFO_DEPTH,
    parameter FIFO_AW = `ASP_FIFO_AW
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire sclk,
    input wire cs_n,
    input wire din,
    output wire dout_rdy_o,
    output wire dout_rdy_oe,
    input wire conv_valid,
    input wire [DATA_W-1:0] conv_data,
    input wire update_soon,
    output wire [2:0] rd_sel,
    input wire [DATA_W-1:0] rd_data,
    output wire wr_valid,
    input wire wr_ready,
    output wire [2:0] wr_sel,
    output wire [DATA_W-1:0] wr_data,
    output wire wr_overrun,
    output wire rdy_n
);

    localparam ST_CMD = 2'h0;
    localparam ST_WR = 2'h1;
    localparam ST_RD = 2'h2;
    localparam FW = DATA_W + 3;

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] sync3_reg;
    reg [2:0] filt_reg;
    wire [2:0] pin_raw;
    wire [2:0] agree;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_active;
    wire din_bit;

    reg [1:0] state_reg;
    reg [4:0] bit_cnt_reg;
    reg [2:0] sel_reg;
    reg [4:0] len_reg;
    reg [DATA_W-1:0] in_sh_reg;
    reg [DATA_W-1:0] out_sh_reg;
    reg out_bit_reg;
    reg out_act_reg;
    reg [DATA_W-1:0] data_reg;
    reg rdy_n_reg;
    reg push_reg;
    reg [FW-1:0] push_data_reg;
    reg overrun_reg;

    wire [7:0] cmd_byte;
    wire [2:0] cmd_sel;
    wire [4:0] cmd_len;
    wire [DATA_W-1:0] word_in;
    wire [DATA_W-1:0] rd_value;
    wire fifo_in_ready;
    wire [FW-1:0] fifo_out;
    wire data_read_done;

    // ------------------------------------------------------------------------
    // register length per select
    // ------------------------------------------------------------------------
    function [4:0] sel_len;
        input [2:0] s;
        begin
            case (s)
                `ASP_SEL_COMM: sel_len = `ASP_LEN_COMM;
                `ASP_SEL_MODE: sel_len = `ASP_LEN_MODE;
                `ASP_SEL_CONF: sel_len = `ASP_LEN_CONF;
                `ASP_SEL_DATA: sel_len = `ASP_LEN_DATA;
                `ASP_SEL_IDENT: sel_len = `ASP_LEN_IDENT;
                `ASP_SEL_GPIO: sel_len = `ASP_LEN_GPIO;
                `ASP_SEL_OFFS: sel_len = `ASP_LEN_OFFS;
                default: sel_len = `ASP_LEN_GAIN;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // bit 0 serial clock, bit 1 select, bit 2 data-in
    assign pin_raw = {din, cs_n, sclk};

    // three stages per pin; a level counts only once stages two and three agree,
    // which also rejects a single-cycle glitch on the slow host clock
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                    sync3_reg[gi] <= 1'b1;
                    filt_reg[gi] <= 1'b1;
                end else if (clk_en) begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (agree[gi]) begin
                        filt_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
            assign agree[gi] = (sync2_reg[gi] == sync3_reg[gi]);
        end
    endgenerate

    // edges are taken as the filtered level is about to change, saving a cycle
    assign cs_active = ~filt_reg[1];
    assign sclk_rise = agree[0] & sync3_reg[0] & ~filt_reg[0] & cs_active;
    assign sclk_fall = agree[0] & ~sync3_reg[0] & filt_reg[0] & cs_active;
    assign din_bit = sync3_reg[2];

    // ------------------------------------------------------------------------
    // command decode and read source
    // ------------------------------------------------------------------------
    assign cmd_byte = {in_sh_reg[6:0], din_bit};
    assign cmd_sel = cmd_byte[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO];
    assign cmd_len = sel_len(cmd_sel);
    assign word_in = {in_sh_reg[DATA_W-2:0], din_bit};
    // select bits of the byte still being shifted, ready on its last bit
    assign rd_sel = in_sh_reg[4:2];
    // the data register is held here, every other register comes from outside
    assign rd_value = (cmd_sel == `ASP_SEL_DATA) ? data_reg : rd_data;
    assign data_read_done = sclk_rise & (state_reg == ST_RD) & (bit_cnt_reg == len_reg - 5'h01)
        & (sel_reg == `ASP_SEL_DATA);

    // ------------------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------------------
    // counting bits per edge rather than per burst lets the host pause anywhere
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 5'h00;
            sel_reg <= `ASP_SEL_COMM;
            len_reg <= `ASP_LEN_COMM;
            in_sh_reg <= {DATA_W{1'b0}};
            out_sh_reg <= {DATA_W{1'b0}};
            out_bit_reg <= 1'b1;
            out_act_reg <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= {FW{1'b0}};
            overrun_reg <= 1'b0;
        end else if (clk_en) begin
            push_reg <= 1'b0;
            overrun_reg <= 1'b0;
            if (!cs_active) begin
                // deselect abandons any partial word and restarts at a command
                state_reg <= ST_CMD;
                bit_cnt_reg <= 5'h00;
                out_act_reg <= 1'b0;
            end else if (sclk_rise) begin
                case (state_reg)
                    ST_CMD: begin
                        in_sh_reg <= word_in;
                        if (bit_cnt_reg == `ASP_CMD_BITS - 5'h01) begin
                            bit_cnt_reg <= 5'h00;
                            sel_reg <= cmd_sel;
                            len_reg <= cmd_len;
                            // a set enable bit means the byte is not a command
                            if (cmd_byte[`ASP_CMD_WEN_BIT]) begin
                                state_reg <= ST_CMD;
                            end else if (cmd_byte[`ASP_CMD_READ_BIT]) begin
                                // left-align so the first bit out is the top one
                                out_sh_reg <= rd_value << (DATA_W[4:0] - cmd_len);
                                state_reg <= ST_RD;
                            end else if (cmd_sel == `ASP_SEL_COMM) begin
                                state_reg <= ST_CMD;
                            end else begin
                                // start the write word from zero so no command bits ride above it
                                in_sh_reg <= {DATA_W{1'b0}};
                                state_reg <= ST_WR;
                            end
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                    ST_WR: begin
                        in_sh_reg <= word_in;
                        if (bit_cnt_reg == len_reg - 5'h01) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg <= ST_CMD;
                            // a full buffer cannot stall the host clock, so the word is dropped
                            if (fifo_in_ready) begin
                                push_reg <= 1'b1;
                                push_data_reg <= {sel_reg, word_in};
                            end else begin
                                overrun_reg <= 1'b1;
                            end
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                    ST_RD: begin
                        if (bit_cnt_reg == len_reg - 5'h01) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg <= ST_CMD;
                            out_act_reg <= 1'b0;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                    default: begin
                        state_reg <= ST_CMD;
                        bit_cnt_reg <= 5'h00;
                    end
                endcase
            end else if (sclk_fall && state_reg == ST_RD) begin
                // new bit only on the falling edge, stable for the host's rising edge
                out_bit_reg <= out_sh_reg[DATA_W-1];
                out_sh_reg <= {out_sh_reg[DATA_W-2:0], 1'b0};
                out_act_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // data register and ready indication
    // ------------------------------------------------------------------------
    // a new result wins over both ways of raising ready in the same cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= {DATA_W{1'b0}};
            rdy_n_reg <= `ASP_RDY_RESET;
        end else if (clk_en) begin
            if (conv_valid) begin
                data_reg <= conv_data;
                rdy_n_reg <= 1'b0;
            end else if (update_soon || data_read_done) begin
                rdy_n_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // shared output pin
    // ------------------------------------------------------------------------
    // falling edge of the ready level is the host's data-valid interrupt
    assign dout_rdy_o = out_act_reg ? out_bit_reg : rdy_n_reg;
    assign dout_rdy_oe = cs_active;
    assign rdy_n = rdy_n_reg;
    assign wr_overrun = overrun_reg;

    // ------------------------------------------------------------------------
    // write buffer toward the register file
    // ------------------------------------------------------------------------
    asp_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_wr_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(push_reg),
        .in_ready(fifo_in_ready),
        .in_data(push_data_reg),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out)
    );

    assign wr_sel = fifo_out[FW-1:DATA_W];
    assign wr_data = fifo_out[DATA_W-1:0];

endmodule // asp_serial_port

// ---- asp_consts.vh ----
// constants for the serial host port of the converter: command byte layout,
// register selects, register lengths, buffer sizes.
// assumes it is included by bare name from every design file that needs it.
// Function
// - during a register read the shared output pin carries the output shift register.
// - output shift register loads from any data or control register.
// - outside a read the shared pin shows ready, going low on a completed result.
// - an unread result lets ready return high before the next update.
// - falling edge of ready marks valid data, usable as a host interrupt.
// - with select low, bits change on clock fall; host samples on clock rise.
// - write data shifted in on data-in goes to the register the select bits name.
// - select bits all zero address the command register; every transfer starts there.
// - active-low select may be tied low for three-wire operation.
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH

// ----------------------------------------------------------------------------
// command byte
// ----------------------------------------------------------------------------
`define ASP_CMD_BITS 5'h08
`define ASP_CMD_WEN_BIT 7
`define ASP_CMD_READ_BIT 6
`define ASP_CMD_SEL_HI 5
`define ASP_CMD_SEL_LO 3

// ----------------------------------------------------------------------------
// register selects
// ----------------------------------------------------------------------------
`define ASP_SEL_COMM 3'h0
`define ASP_SEL_MODE 3'h1
`define ASP_SEL_CONF 3'h2
`define ASP_SEL_DATA 3'h3
`define ASP_SEL_IDENT 3'h4
`define ASP_SEL_GPIO 3'h5
`define ASP_SEL_OFFS 3'h6
`define ASP_SEL_GAIN 3'h7

// ----------------------------------------------------------------------------
// register lengths in bits, per select
// ----------------------------------------------------------------------------
`define ASP_LEN_COMM 5'h08
`define ASP_LEN_MODE 5'h10
`define ASP_LEN_CONF 5'h10
`define ASP_LEN_DATA 5'h18
`define ASP_LEN_IDENT 5'h08
`define ASP_LEN_GPIO 5'h08
`define ASP_LEN_OFFS 5'h18
`define ASP_LEN_GAIN 5'h18

// ----------------------------------------------------------------------------
// data path sizes and reset values
// ----------------------------------------------------------------------------
`define ASP_DATA_W 24
`define ASP_FIFO_DEPTH 8
`define ASP_FIFO_AW 3
`define ASP_RDY_RESET 1'b1

`endif

// ---- asp_fifo.v ----
// small first-in first-out buffer with valid/ready on both sides and a
// registered output stage.
// assumes one clock, an asynchronous active-low reset and a clock enable.
`timescale 1ns/10ps
`include "asp_consts.vh"

module asp_fifo #(
    parameter WIDTH = 27,
    parameter DEPTH = `ASP_FIFO_DEPTH,
    parameter AW = `ASP_FIFO_AW
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    reg [WIDTH-1:0] out_data_reg;
    reg out_valid_reg;
    wire [AW:0] count;
    wire push;
    wire pull;

    // ------------------------------------------------------------------------
    // pointers and flags
    // ------------------------------------------------------------------------
    // extra pointer bit tells full from empty without a separate counter
    assign count = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (count != DEPTH[AW:0]);
    assign push = in_valid & in_ready;
    assign pull = (count != {(AW+1){1'b0}}) & (~out_valid_reg | out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    // storage has no reset, only the pointers and the output stage do
    always @(posedge clk) begin
        if (clk_en && push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // registered output stage refills whenever it empties or is taken
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            out_data_reg <= {WIDTH{1'b0}};
            out_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pull) begin
                out_data_reg <= mem[rd_ptr_reg[AW-1:0]];
                out_valid_reg <= 1'b1;
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

endmodule // asp_fifo

// ---- asp_port_assertions.sv ----
// concurrent checks on the pins and side ports of the serial host port.
// assumes one clock domain with an asynchronous active-low reset; bound by name.
`timescale 1ns/10ps

module asp_port_assertions #(
    parameter DATA_W = 24
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire sclk,
    input wire cs_n,
    input wire conv_valid,
    input wire update_soon,
    input wire dout_rdy_o,
    input wire dout_rdy_oe,
    input wire rdy_n,
    input wire wr_valid,
    input wire wr_ready,
    input wire [2:0] wr_sel,
    input wire [DATA_W-1:0] wr_data
);
    // ------------------------------------------------------------------
    // helper: cycles since clock or select pin last moved
    // ------------------------------------------------------------------
    reg [1:0] pins_reg;
    reg [3:0] quiet_reg;

    // the sync chain delays the pin by a few cycles, so allow up to 7
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_reg <= 2'h3;
            quiet_reg <= 4'hF;
        end else begin
            pins_reg <= {sclk, cs_n};
            if ({sclk, cs_n} != pins_reg) quiet_reg <= 4'h0;
            else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
        end
    end

    conv_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && conv_valid |=> !rdy_n) else $error("ready not low after a result");
    upd_raise_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && update_soon && !conv_valid |=> rdy_n) else $error("ready not back high before update");
    rdy_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(rdy_n) |-> $past(conv_valid)) else $error("ready fell with no new result");
    oe_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        cs_n [*7] |-> !dout_rdy_oe) else $error("pin driven while deselected");
    oe_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        !cs_n [*7] |-> dout_rdy_oe) else $error("pin not driven while selected");
    bit_timing_a: assert property (@(posedge clk) disable iff (!reset_n)
        dout_rdy_oe && $past(dout_rdy_oe) && $changed(dout_rdy_o) && !$past(conv_valid)
        && !$past(update_soon) |-> quiet_reg < 4'h8) else $error("data-out moved without a clock edge");
    wr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_valid && !wr_ready |=> wr_valid && $stable({wr_sel, wr_data}))
        else $error("write word not held while stalled");
    wr_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_valid |-> wr_sel != 3'h0) else $error("write word aimed at the command register");
endmodule // asp_port_assertions

// ---- asp_host_model.sv ----
// serial master standing in for the host controller on the port's pins.
// assumes the bench resolves the shared data-out/ready wire and hands it in.
`timescale 1ns/10ps

module asp_host_model (
    output reg sclk,
    output reg cs_n,
    output reg din,
    input wire dout
);
    // ------------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------------
    reg tie_cs; // three-wire use: select left low between frames
    reg cmd_bit; // pin level during the first command bit
    reg [23:0] rd_word;

    // clock parked high between frames, select inactive
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
        tie_cs = 1'b0;
    end

    // data moves on the fall; the reply lands late, so look well after the rise
    task bit_cycle(input b, output s);
        begin
            sclk = 1'b0;
            din = b;
            #80;
            sclk = 1'b1;
            #40;
            s = dout;
            #40;
        end
    endtask

    // command byte, then n bits each way, msb first; gap splits the burst
    task frame(input [7:0] cmd, input integer n, input [23:0] w, input integer gap);
        integer i;
        reg s;
        begin
            cs_n = 1'b0;
            #200;
            for (i = 7; i >= 0; i = i - 1) begin
                bit_cycle(cmd[i], s);
                if (i == 7) cmd_bit = s;
            end
            #(gap);
            rd_word = 24'h0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                bit_cycle(w[i], s);
                rd_word[i] = s;
            end
            #200;
            cs_n = ~tie_cs;
            din = ~din; // line stays restless outside frames
            #200;
        end
    endtask

    // word cut short by select, then a write-like burst while deselected
    task stray(input integer k);
        integer i;
        reg s;
        begin
            cs_n = 1'b0;
            #200;
            for (i = 0; i < k; i = i + 1) bit_cycle(i[0], s);
            cs_n = 1'b1;
            #200;
            for (i = 0; i < 8; i = i + 1) bit_cycle(i == 4, s);
            #200;
        end
    endtask
endmodule // asp_host_model

// ---- tb.sv ----
// bench for the serial host port: host model on the pins, result and register
// sources and a stalling write sink on the side ports, scoreboard per write word.
// assumes the design, its constants header and the host model compile first.
`timescale 1ns/10ps

module tb;
    reg clk = 1'b0, reset_n = 1'b0, conv_valid = 1'b0, update_soon = 1'b0;
    reg wr_ready = 1'b0, sink_on = 1'b1;
    reg [23:0] conv_data = 24'h0, data_m;
    reg [23:0] regs [0:7];
    reg [26:0] exp_q [$];
    integer error_cnt = 0, tests_run = 0, ovr_cnt = 0, seed = 32'h7C6E, i, k;
    wire sclk, cs_n, din, dout_rdy_o, dout_rdy_oe, wr_valid, wr_overrun, rdy_n;
    wire [2:0] rd_sel, wr_sel;
    wire [23:0] rd_data, wr_data;
    wire dout = dout_rdy_oe ? dout_rdy_o : 1'bz; // no pull on the shared wire

    assign rd_data = regs[rd_sel];
    always #10 clk = ~clk;

    asp_serial_port asp_serial_port_inst (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe), .conv_valid(conv_valid),
        .conv_data(conv_data), .update_soon(update_soon), .rd_sel(rd_sel), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_sel(wr_sel), .wr_data(wr_data),
        .wr_overrun(wr_overrun), .rdy_n(rdy_n));
    asp_host_model asp_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    // ------------------------------------------------------------------
    // scoreboard helpers
    // ------------------------------------------------------------------
    function integer len(input [2:0] s);
        case (s)
            3'h1, 3'h2: len = 16;
            3'h3, 3'h6, 3'h7: len = 24;
            default: len = 8;
        endcase
    endfunction

    function [23:0] mask(input [2:0] s);
        mask = (24'h1 << len(s)) - 24'h1;
    endfunction

    task check(input string what, input logic [26:0] seen, input logic [26:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // one-cycle result pulse; ready must read low one cycle on
    task result;
        begin
            @(posedge clk);
            conv_valid <= 1'b1;
            conv_data <= $random(seed);
            @(posedge clk);
            conv_valid <= 1'b0;
            data_m = conv_data;
            #1;
            check("ready after result", 27'(rdy_n), 27'h0);
        end
    endtask

    task rd_reg(input [2:0] sel, input [23:0] exp, input integer gap);
        begin
            asp_host_model_inst.frame({2'b01, sel, 3'b000}, len(sel), 24'h0, gap);
            check("read word", 27'(asp_host_model_inst.rd_word), 27'(exp));
        end
    endtask

    // keep=0 models a word the full buffer has to drop
    task wr_reg(input [2:0] sel, input keep);
        reg [23:0] d;
        begin
            d = $random(seed) & mask(sel);
            if (keep) exp_q.push_back({sel, d});
            asp_host_model_inst.frame({2'b00, sel, 3'b000}, len(sel), d, 0);
        end
    endtask

    // write sink stalls at random and checks every word taken
    always @(posedge clk) begin
        wr_ready <= sink_on && ($random(seed) & 1);
        if (wr_valid === 1'b1 && wr_ready) begin
            if (exp_q.size() == 0) check("spare write", 27'h1, 27'h0);
            else check("write word", {wr_sel, wr_data}, exp_q.pop_front());
        end
        if (wr_overrun === 1'b1) ovr_cnt <= ovr_cnt + 1;
    end

    initial begin
        #1500000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (i = 0; i < 8; i = i + 1) regs[i] = $random(seed);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("ready after reset", 27'(rdy_n), 27'h1);
        check("pin enable idle", 27'(dout_rdy_oe), 27'h0);
        for (i = 0; i < 8; i = i + 1) if (i != 3) rd_reg(i[2:0], regs[i] & mask(i[2:0]), 0);
        result;
        asp_host_model_inst.frame(8'h58, 24, 24'h0, 1000);
        check("ready on pin", 27'(asp_host_model_inst.cmd_bit), 27'h0);
        check("result word", 27'(asp_host_model_inst.rd_word), 27'(data_m));
        check("ready after read", 27'(rdy_n), 27'h1);
        result;
        result;
        @(posedge clk);
        update_soon <= 1'b1;
        @(posedge clk);
        update_soon <= 1'b0;
        #1;
        check("ready before update", 27'(rdy_n), 27'h1);
        rd_reg(3'h3, data_m, 0);
        check("ready on pin", 27'(asp_host_model_inst.cmd_bit), 27'h1);
        for (i = 1; i < 8; i = i + 1) if (i != 3) wr_reg(i[2:0], 1'b1);
        asp_host_model_inst.frame(8'h00, 0, 24'h0, 0);
        asp_host_model_inst.stray(5);
        wr_reg(3'h2, 1'b1);
        sink_on = 1'b0;
        // output stage plus eight stored words fill up, the tenth word is dropped
        for (i = 0; i < 10; i = i + 1) wr_reg(3'h5, i < 9);
        check("dropped words", 27'(ovr_cnt), 27'h1);
        sink_on = 1'b1;
        for (k = 0; k < 300 && exp_q.size() != 0; k = k + 1) @(posedge clk);
        check("words left", 27'(exp_q.size()), 27'h0);
        asp_host_model_inst.tie_cs = 1'b1;
        // enable bit set: byte must be ignored, else the next read is misframed
        asp_host_model_inst.frame(8'h88, 0, 24'h0, 0);
        rd_reg(3'h1, regs[1] & 24'h00FFFF, 0);
        rd_reg(3'h6, regs[6], 0);
        result;
        check("ready on pin", 27'(dout), 27'h0);
        rd_reg(3'h3, data_m, 0);
        tally_and_finish;
    end
endmodule // tb

bind asp_serial_port asp_port_assertions #(.DATA_W(DATA_W)) asp_port_assertions_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .conv_valid(conv_valid),
    .update_soon(update_soon), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe), .rdy_n(rdy_n),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_sel(wr_sel), .wr_data(wr_data));
